//--- rtl/rfa_pkg.sv
// Shared constants and carriers for the register field access bank
package rfa_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCORE = 4;
  localparam int NCU   = 2;
  localparam int AW    = 8;
  localparam int DW    = 32;
  localparam int CW    = 2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CORE = 8'h00;
  localparam logic [AW-1:0] OFS_CU   = 8'h04;
  localparam logic [AW-1:0] OFS_NODE = 8'h08;
  localparam logic [AW-1:0] OFS_COLD = 8'h0c;
  localparam logic [AW-1:0] OFS_GPRD = 8'h10;
  localparam logic [AW-1:0] OFS_GPWR = 8'h14;
  // Broadcast address is the row nibble joined with the column nibble
  localparam logic [3:0]    BC_ROW   = 4'h2;
  localparam logic [3:0]    BC_COL   = 4'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CORE_RW_LSB  = 0;
  localparam int CORE_HW_LSB  = 8;
  localparam int CU_W1O_BIT   = 0;
  localparam int CU_ZERO_BIT  = 1;
  localparam int CU_WO_LSB    = 8;
  localparam int NODE_EVT_LSB = 0;
  localparam int NODE_ZERO_LSB = 8;
  localparam int NODE_FIX_LSB = 16;
  localparam int NODE_RAP_LSB = 24;
  localparam int COLD_CFG_LSB = 0;
  localparam int COLD_X_LSB   = 16;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CORE_RW_RST  = 8'h00;
  localparam logic [7:0]  CU_WO_RST    = 8'h00;
  localparam logic [7:0]  NODE_EVT_RST = 8'h00;
  localparam logic [7:0]  NODE_RAP_RST = 8'h00;
  localparam logic [15:0] COLD_CFG_RST = 16'h0000;
  localparam logic [31:0] GPRD_RST     = 32'h0000_0000;
  localparam logic [7:0]  FIXED_VAL    = 8'h5a;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          valid;
    logic          write;
    logic [CW-1:0] core;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } rfa_req_t;

  typedef struct packed {
    logic          valid;
    logic          gp_fault;
    logic [DW-1:0] rdata;
  } rfa_rsp_t;

endpackage

//--- rtl/rfa_sync2.sv
// Two-flop synchroniser for pin-level inputs
module rfa_sync2 #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Only the second stage reads the first
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

//--- rtl/rfa_w1c_field.sv
// Sticky field set by hardware and cleared by writing ones
module rfa_w1c_field #(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         core_clk_i,
  input  wire logic         srst_i,
  input  wire logic         warm_rst_i,
  input  wire logic [W-1:0] hw_set_i,
  input  wire logic [W-1:0] sw_clr_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // Set wins over a clear in the same cycle so no event is lost
  assign q_d = hw_set_i | (q_q & ~sw_clr_i);

  always_ff @(posedge core_clk_i) begin
    if (srst_i || warm_rst_i) begin
      q_q <= RST;
    end else begin
      q_q <= q_d;
    end
  end

  assign q_o = q_q;
endmodule

//--- rtl/rfa_bank.sv
// Register bank applying per-field access policies for several cores
//
// What this block does
// - Write-1-to-clear bits clear only where a one is written.
// - Write-1-only bits set on a written one; zeros change nothing.
// - Write-only fields take writes; read value is undefined.
// - Read-only fields return their value and ignore writes.
// - Read-as-zero reads zero, ignores writes unless also write-only or write-1-only.
// - Writing one to a must-be-zero bit raises a protection fault.
// - Read- or write-protected registers fault on the tagged access kind.
// - Registers take reset values on warm or cold system reset.
// - Fields with unspecified reset value may come up in any state.
// - Cold-reset fields survive warm reset; reset only while power is not good.
// - Reset-applied fields write anytime outside warm reset, take effect at next warm reset.
// - Fixed-value fields always return their constant, even after reset.
// - Per-core registers: each core reads only its own copy and writes other copies only through the broadcast address.
// - Per-compute-unit registers: a core reaches only its unit's copy.
// - Per-node registers: one shared copy reachable by every core.
// - Hardware-updated fields change on their own; reads show current state.
// - Broadcast address write puts the same data into its whole group.
module rfa_bank (
  input  wire logic                            core_clk_i,
  input  wire logic                            srst_i,
  input  wire logic                            sys_rst_n_i,
  input  wire logic                            power_good_i,
  input  wire rfa_pkg::rfa_req_t               req_i,
  output rfa_pkg::rfa_rsp_t                    rsp_o,
  input  wire logic [rfa_pkg::NCORE-1:0][7:0]  hw_status_i,
  input  wire logic [7:0]                      hw_event_i,
  output logic      [rfa_pkg::NCORE-1:0][7:0]  core_ctrl_o,
  output logic      [rfa_pkg::NCU-1:0][7:0]    cu_wo_o,
  output logic      [rfa_pkg::NCU-1:0]         cu_flag_o,
  output logic      [7:0]                      node_mode_o,
  output logic      [15:0]                     cold_cfg_o,
  output logic      [7:0]                      event_flags_o
);
  import rfa_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Two neighbouring cores share one compute unit
  function automatic logic [CW-2:0] cu_of(input logic [CW-1:0] core);
    cu_of = core[CW-1:1];
  endfunction

  function automatic logic addr_is(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    addr_is = (a[AW-1:2] == ofs[AW-1:2]);
  endfunction

  // ----------------------------------------------------------------
  // Reset pins
  // ----------------------------------------------------------------
  // Both pins are asynchronous to the core clock, so they are resynchronised
  // before use; a reset shorter than one cycle may be missed.
  logic sys_rst_n_s;
  logic power_good_s;
  logic warm_rst;
  logic cold_rst;

  rfa_sync2 #(
    .W   (1),
    .RST (1'b0)
  ) u_sync_rst (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    (sys_rst_n_i),
    .sync_o     (sys_rst_n_s)
  );

  rfa_sync2 #(
    .W   (1),
    .RST (1'b0)
  ) u_sync_pwr (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .async_i    (power_good_i),
    .sync_o     (power_good_s)
  );

  assign cold_rst = ~power_good_s;
  // A power loss is also a warm reset of everything else
  assign warm_rst = ~sys_rst_n_s | cold_rst;

  // ----------------------------------------------------------------
  // Reset classes
  // ----------------------------------------------------------------
  // Clear terms shared by every register of one reset class
  wire             warm_clr = srst_i | warm_rst;
  wire             cold_clr = srst_i | cold_rst;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire             req_wr   = req_i.valid & req_i.write;
  wire             req_rd   = req_i.valid & ~req_i.write;
  wire [CW-2:0]    req_cu   = cu_of(req_i.core);
  wire             hit_core = addr_is(req_i.addr, OFS_CORE);
  wire             hit_cu   = addr_is(req_i.addr, OFS_CU);
  wire             hit_node = addr_is(req_i.addr, OFS_NODE);
  wire             hit_cold = addr_is(req_i.addr, OFS_COLD);
  wire             hit_gprd = addr_is(req_i.addr, OFS_GPRD);
  wire             hit_gpwr = addr_is(req_i.addr, OFS_GPWR);
  wire             hit_bc   = addr_is(req_i.addr, {BC_ROW, BC_COL});

  // ----------------------------------------------------------------
  // Protection faults
  // ----------------------------------------------------------------
  wire             gp_zero  = req_wr & hit_cu & req_i.wdata[CU_ZERO_BIT];
  wire             gp_prot  = (req_rd & hit_gprd) | (req_wr & hit_gpwr);
  wire             gp_any   = gp_zero | gp_prot;

  // Faulting writes and writes under warm reset change nothing
  wire             wr_ok    = req_wr & ~gp_any & ~warm_rst;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // Write data is sliced once here so the register blocks stay plain loads
  wire [7:0]       core_rw_d  = req_i.wdata[CORE_RW_LSB +: 8];
  wire [7:0]       cu_wo_d    = req_i.wdata[CU_WO_LSB +: 8];
  wire             w1o_one    = req_i.wdata[CU_W1O_BIT];
  wire [7:0]       rap_pend_d = req_i.wdata[NODE_RAP_LSB +: 8];
  wire [15:0]      cold_cfg_d = req_i.wdata[COLD_CFG_LSB +: 16];
  wire [15:0]      xfld_d     = req_i.wdata[COLD_X_LSB +: 16];

  // ----------------------------------------------------------------
  // Per-core registers
  // ----------------------------------------------------------------
  logic [NCORE-1:0][7:0] core_rw_q;

  for (genvar c = 0; c < NCORE; c++) begin : g_core
    wire core_own = hit_core & (req_i.core == CW'(c));
    // Own copy only, unless the broadcast address hits the whole group
    wire core_we  = wr_ok & (core_own | hit_bc);

    always_ff @(posedge core_clk_i) begin
      if (warm_clr) begin
        core_rw_q[c] <= CORE_RW_RST;
      end else if (core_we) begin
        core_rw_q[c] <= core_rw_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-compute-unit registers
  // ----------------------------------------------------------------
  logic [NCU-1:0]      cu_w1o_q;
  logic [NCU-1:0][7:0] cu_wo_q;

  for (genvar u = 0; u < NCU; u++) begin : g_cu
    wire cu_we    = wr_ok & hit_cu & (req_cu == (CW-1)'(u));
    // Only a written one sets; a zero leaves the bit alone
    wire cu_w1o_d = cu_w1o_q[u] | w1o_one;

    always_ff @(posedge core_clk_i) begin
      if (warm_clr) begin
        cu_w1o_q[u] <= 1'b0;
      end else if (cu_we) begin
        cu_w1o_q[u] <= cu_w1o_d;
      end
    end

    // Write-only data only drives the output; reads never show it
    always_ff @(posedge core_clk_i) begin
      if (warm_clr) begin
        cu_wo_q[u] <= CU_WO_RST;
      end else if (cu_we) begin
        cu_wo_q[u] <= cu_wo_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-node registers
  // ----------------------------------------------------------------
  // One shared copy; cores must take turns, the bank does not arbitrate
  logic [7:0]  evt_q;
  logic [7:0]  rap_pend_q;
  logic [7:0]  rap_act_q;
  logic [15:0] cold_cfg_q;
  logic [15:0] xfld_q;
  logic [31:0] gprd_q;
  logic [7:0]  gp_cnt_q;

  wire         node_we = wr_ok & hit_node;
  wire         cold_we = wr_ok & hit_cold;
  wire  [7:0]  evt_clr = node_we ? req_i.wdata[NODE_EVT_LSB +: 8] : 8'h00;

  rfa_w1c_field #(
    .W   (8),
    .RST (NODE_EVT_RST)
  ) u_evt (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .warm_rst_i (warm_rst),
    .hw_set_i   (hw_event_i),
    .sw_clr_i   (evt_clr),
    .q_o        (evt_q)
  );

  // The pending copy survives warm reset so the setting is not lost
  always_ff @(posedge core_clk_i) begin
    if (cold_clr) begin
      rap_pend_q <= NODE_RAP_RST;
    end else if (node_we) begin
      rap_pend_q <= rap_pend_d;
    end
  end

  // The active copy only moves while warm reset is held
  always_ff @(posedge core_clk_i) begin
    if (cold_clr) begin
      rap_act_q <= NODE_RAP_RST;
    end else if (warm_rst) begin
      rap_act_q <= rap_pend_q;
    end
  end

  // ----------------------------------------------------------------
  // Cold-reset registers
  // ----------------------------------------------------------------
  // Only a power loss clears this field; a warm reset rides through
  always_ff @(posedge core_clk_i) begin
    if (cold_clr) begin
      cold_cfg_q <= COLD_CFG_RST;
    end else if (cold_we) begin
      cold_cfg_q <= cold_cfg_d;
    end
  end

  // No reset at all: contents are unspecified until first written
  always_ff @(posedge core_clk_i) begin
    if (cold_we) begin
      xfld_q <= xfld_d;
    end
  end

  // ----------------------------------------------------------------
  // Protected registers
  // ----------------------------------------------------------------
  // Writable scratch whose reads are protected
  wire         gprd_we   = wr_ok & hit_gprd;

  always_ff @(posedge core_clk_i) begin
    if (warm_clr) begin
      gprd_q <= GPRD_RST;
    end else if (gprd_we) begin
      gprd_q <= req_i.wdata;
    end
  end

  // Hardware-kept fault count; it saturates so a flood of faults cannot wrap it
  wire         gp_cnt_en = req_i.valid & gp_any & (gp_cnt_q != 8'hff);
  wire  [7:0]  gp_cnt_d  = gp_cnt_q + 8'h01;

  always_ff @(posedge core_clk_i) begin
    if (warm_clr) begin
      gp_cnt_q <= 8'h00;
    end else if (gp_cnt_en) begin
      gp_cnt_q <= gp_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] rd_core = {16'h0000, hw_status_i[req_i.core], core_rw_q[req_i.core]};
  // Write-only, read-as-zero and must-be-zero bits all read as zero
  wire [31:0] rd_cu   = {16'h0000, 8'h00, 7'h00, cu_w1o_q[req_cu]};
  wire [31:0] rd_node = {rap_pend_q, FIXED_VAL, 8'h00, evt_q};
  wire [31:0] rd_cold = {xfld_q, cold_cfg_q};
  wire [31:0] rd_gpwr = {24'h00_0000, gp_cnt_q};

  logic [31:0] rdata_d;

  // ----------------------------------------------------------------
  // Read select
  // ----------------------------------------------------------------
  // A faulting read returns zero so protected contents never leak
  wire         rd_ok = req_rd & ~gp_any;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_ok) begin
      case (1'b1)
        hit_core: rdata_d = rd_core;
        hit_cu:   rdata_d = rd_cu;
        hit_node: rdata_d = rd_node;
        hit_cold: rdata_d = rd_cold;
        hit_gpwr: rdata_d = rd_gpwr;
        default:  rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  rfa_rsp_t rsp_q;
  rfa_rsp_t rsp_d;

  // Every request is answered next cycle, faulted or not
  assign rsp_d.valid    = req_i.valid;
  assign rsp_d.gp_fault = req_i.valid & gp_any;
  assign rsp_d.rdata    = rdata_d;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_o         = rsp_q;
  assign core_ctrl_o   = core_rw_q;
  assign cu_wo_o       = cu_wo_q;
  assign cu_flag_o     = cu_w1o_q;
  assign node_mode_o   = rap_act_q;
  assign cold_cfg_o    = cold_cfg_q;
  assign event_flags_o = evt_q;

endmodule

//--- verification/rfa_bank_assertions.sv
// Concurrent checks on the ports of the register field access bank
module rfa_bank_assertions (
  input logic                           core_clk_i,
  input logic                           srst_i,
  input logic                           sys_rst_n_i,
  input logic                           power_good_i,
  input rfa_pkg::rfa_req_t              req_i,
  input rfa_pkg::rfa_rsp_t              rsp_o,
  input logic [rfa_pkg::NCORE-1:0][7:0] core_ctrl_o,
  input logic [rfa_pkg::NCU-1:0][7:0]   cu_wo_o,
  input logic [rfa_pkg::NCU-1:0]        cu_flag_o,
  input logic [7:0]                     node_mode_o,
  input logic [7:0]                     event_flags_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import rfa_pkg::*;
  // Pins must stay high past the synchroniser before writes count
  logic [1:0] ok_cnt_q;
  logic       ok;
  logic       wr;
  logic       rd;
  logic [5:0] wa;
  assign ok = (ok_cnt_q == 2'h3) && sys_rst_n_i && power_good_i;
  assign wr = req_i.valid && req_i.write;
  assign rd = req_i.valid && !req_i.write;
  assign wa = req_i.addr[7:2];
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !sys_rst_n_i || !power_good_i) ok_cnt_q <= 2'h0;
    else if (ok_cnt_q != 2'h3) ok_cnt_q <= ok_cnt_q + 2'h1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_rsp_next: assert property (req_i.valid |=> rsp_o.valid)
    else $error("no response one cycle after request");
  a_fixed_value: assert property (rd && wa == OFS_NODE[7:2] |=> rsp_o.rdata[23:16] == FIXED_VAL)
    else $error("fixed field read wrong");
  a_read_zero: assert property (rd && wa == OFS_NODE[7:2] |=> rsp_o.rdata[15:8] == 8'h00)
    else $error("read-as-zero field not zero");
  a_gp_read: assert property (rd && wa == OFS_GPRD[7:2] |=> rsp_o.gp_fault)
    else $error("protected read without fault");
  a_gp_write: assert property (wr && wa == OFS_GPWR[7:2] |=> rsp_o.gp_fault)
    else $error("protected write without fault");
  a_zero_bit_fault: assert property (ok && wr && wa == OFS_CU[7:2] && req_i.wdata[CU_ZERO_BIT]
    |=> rsp_o.gp_fault && $stable(cu_wo_o) && $stable(cu_flag_o))
    else $error("must-be-zero write not faulted or not dropped");
  a_w1c_keep: assert property (ok && wr && wa == OFS_NODE[7:2] && req_i.wdata[7:0] == 8'h00
    |=> (event_flags_o & $past(event_flags_o)) == $past(event_flags_o))
    else $error("flag cleared by a written zero");
  a_w1o_set: assert property (ok && wr && wa == OFS_CU[7:2] && req_i.wdata[1:0] == 2'b01
    |=> cu_flag_o[$past(req_i.core[CW-1])])
    else $error("write-1-only bit not set");
  a_core_own: assert property (ok && wr && wa == OFS_CORE[7:2]
    |=> core_ctrl_o[$past(req_i.core)] == $past(req_i.wdata[7:0]))
    else $error("per-core write missed its copy");
  a_bcast_all: assert property (ok && wr && req_i.addr == {BC_ROW, BC_COL}
    |=> core_ctrl_o == {NCORE{$past(req_i.wdata[7:0])}})
    else $error("broadcast did not reach every copy");
  a_mode_hold: assert property (ok |=> $stable(node_mode_o))
    else $error("reset-applied field moved outside warm reset");
  c_node_wr: cover property (ok && wr && wa == OFS_NODE[7:2]);
  c_fault: cover property (rsp_o.gp_fault);
  c_warm: cover property (!sys_rst_n_i ##1 sys_rst_n_i);
endmodule

//--- verification/rfa_bank_tb_top.sv
// Directed self-checking bench for the register field access bank
module rfa_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rfa_pkg::*;
  logic                  core_clk_i = 1'b0;
  logic                  srst_i = 1'b1;
  logic                  sys_rst_n_i = 1'b1;
  logic                  power_good_i = 1'b1;
  rfa_req_t              req_i = '0;
  rfa_rsp_t              rsp_o;
  logic [NCORE-1:0][7:0] hw_status_i = '0;
  logic [7:0]            hw_event_i = 8'h00;
  logic [NCORE-1:0][7:0] core_ctrl_o;
  logic [NCU-1:0][7:0]   cu_wo_o;
  logic [NCU-1:0]        cu_flag_o;
  logic [7:0]            node_mode_o;
  logic [15:0]           cold_cfg_o;
  logic [7:0]            event_flags_o;
  int                    n_errors = 0;
  int                    n_checks = 0;
  rfa_bank i_dut (.core_clk_i, .srst_i, .sys_rst_n_i, .power_good_i, .req_i, .rsp_o,
    .hw_status_i, .hw_event_i, .core_ctrl_o, .cu_wo_o, .cu_flag_o, .node_mode_o,
    .cold_cfg_o, .event_flags_o);
  always #10 core_clk_i = ~core_clk_i;
  task summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request, answer judged one cycle later
  task bus(input logic w, input logic [1:0] c, input logic [7:0] a, input logic [31:0] d,
           input logic gp, input logic [31:0] exp);
    @(negedge core_clk_i);
    req_i = '{1'b1, w, c, a, d};
    @(negedge core_clk_i);
    req_i.valid = 1'b0;
    chk({rsp_o.valid, rsp_o.gp_fault, rsp_o.rdata}, {1'b1, gp, exp});
  endtask
  // Pins low for a while; power good low makes it a cold reset
  task warm(input logic pg);
    @(negedge core_clk_i);
    sys_rst_n_i = 1'b0;
    power_good_i = pg;
    repeat (5) @(negedge core_clk_i);
    sys_rst_n_i = 1'b1;
    power_good_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
  endtask
  task t_core();
    for (int c = 0; c < NCORE; c++) begin
      bus(1, 2'(c), OFS_CORE, {24'hffffff, 8'(8'h10 + c)}, 0, 0);
    end
    hw_status_i = {8'h44, 8'h33, 8'h22, 8'h11};
    for (int c = 0; c < NCORE; c++) begin
      bus(0, 2'(c), OFS_CORE, 0, 0, {16'h0, hw_status_i[c], 8'(8'h10 + c)});
    end
    bus(1, 0, {BC_ROW, BC_COL}, 32'h0000_00c3, 0, 0);
    chk({2'b0, core_ctrl_o}, {2'b0, {4{8'hc3}}});
  endtask
  task t_cu();
    bus(1, 0, OFS_CU, 32'h0000_ab01, 0, 0);
    bus(0, 1, OFS_CU, 0, 0, 32'h1);
    bus(0, 2, OFS_CU, 0, 0, 0);
    bus(1, 1, OFS_CU, 32'h0000_cd00, 0, 0);
    bus(1, 2, OFS_CU, 32'h0000_ee03, 1, 0);
    chk({16'h0, cu_wo_o, cu_flag_o}, {16'h0, 16'h00cd, 2'b01});
  endtask
  task t_node();
    @(negedge core_clk_i);
    hw_event_i = 8'h0f;
    @(negedge core_clk_i);
    hw_event_i = 8'h00;
    bus(0, 0, OFS_NODE, 0, 0, 32'h005a_000f);
    bus(1, 3, OFS_NODE, 32'h77ff_ff00, 0, 0);
    bus(0, 1, OFS_NODE, 0, 0, 32'h775a_000f);
    bus(1, 2, OFS_NODE, 32'h7700_0003, 0, 0);
    // Event and clear in one cycle: the set must win
    hw_event_i = 8'h01;
    bus(1, 0, OFS_NODE, 32'h7700_0001, 0, 0);
    hw_event_i = 8'h00;
    chk({18'h0, node_mode_o, event_flags_o}, {18'h0, 8'h00, 8'h0d});
    warm(1);
    chk({10'h0, node_mode_o, event_flags_o, core_ctrl_o[0]}, {10'h0, 24'h770000});
    bus(0, 3, OFS_NODE, 0, 0, 32'h775a_0000);
  endtask
  task t_gp();
    bus(1, 0, OFS_GPRD, 32'h1234_5678, 0, 0);
    bus(0, 0, OFS_GPRD, 0, 1, 0);
    bus(1, 0, OFS_GPWR, 32'h0000_00ff, 1, 0);
    bus(0, 0, OFS_GPWR, 0, 0, 32'h2);
    bus(1, 0, 8'h40, 32'hffff_ffff, 0, 0);
    bus(0, 0, 8'h40, 0, 0, 0);
  endtask
  task t_cold();
    bus(1, 0, OFS_COLD, 32'h0000_1234, 0, 0);
    warm(1);
    chk({18'h0, cold_cfg_o}, {18'h0, 16'h1234});
    warm(0);
    chk({10'h0, cold_cfg_o, node_mode_o}, 34'h0);
  endtask
  initial begin
    repeat (3) @(negedge core_clk_i);
    srst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    t_core();
    t_cu();
    t_node();
    t_gp();
    t_cold();
    summarize();
  end
  // A hang counts as a mismatch
  initial begin
    #200us;
    n_errors++;
    summarize();
  end
endmodule
bind rfa_bank rfa_bank_assertions i_chk (.core_clk_i, .srst_i, .sys_rst_n_i, .power_good_i,
  .req_i, .rsp_o, .core_ctrl_o, .cu_wo_o, .cu_flag_o, .node_mode_o, .event_flags_o);
